// ### ncr_restore.v
// stored configuration restore engine for a dual output regulator controller
// assumes a command decoder on REF_CLK_I presenting one written byte per pulse
// Function
// - on restore command with data while outputs are disabled (OUT_EN_I low), copy every word of chosen set to active settings
// - restore is global, independent of the selected output page
// - restore carries exactly one data byte and is write only
// - set number comes from data bits 3:0; bits 7:4 are reserved
`timescale 1ns/1ps
`include "ncr_map.vh"
module ncr_restore #(
  parameter SEL_W = 4,
  parameter IDX_W = 4,
  parameter DW = 16
) (
  input wire REF_CLK_I,
  input wire SYS_RST_I,
  input wire CMD_WR_I,
  input wire [7:0] CMD_CODE_I,
  input wire [7:0] CMD_DATA_I,
  input wire [7:0] CMD_LEN_I,
  input wire [1:0] PAGE_I,
  input wire OUT_EN_I,
  input wire NVM_WR_I,
  input wire [SEL_W+IDX_W-1:0] NVM_WADDR_I,
  input wire [DW-1:0] NVM_WDATA_I,
  output wire BUSY_O,
  output reg ACT_WR_O,
  output reg [IDX_W-1:0] ACT_ADDR_O,
  output reg [DW-1:0] ACT_DATA_O,
  output reg DONE_O,
  output reg REFUSED_O,
  output reg [SEL_W-1:0] LAST_SET_O
);
  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_COPY = 2'b10;
  localparam integer LAST_IDX_INT = `NCR_WORDS_PER_SET - 1;
  localparam [IDX_W-1:0] LAST_IDX = LAST_IDX_INT[IDX_W-1:0];
  reg [1:0] state_reg, state_next;
  reg [SEL_W-1:0] set_reg, set_next;
  reg [IDX_W-1:0] idx_reg, idx_next;
  reg [IDX_W-1:0] wr_idx_reg;
  reg copy_en_reg;
  wire [DW-1:0] rd_data;
  wire cmd_hit;
  wire len_ok;
  // page select is not part of the match
  assign cmd_hit = CMD_WR_I && (CMD_CODE_I == `NCR_CMD_RESTORE);
  assign len_ok = (CMD_LEN_I == 8'h01);
  assign BUSY_O = (state_reg != ST_IDLE);
  ncr_mem #(.AW(SEL_W+IDX_W), .DW(DW)) u_mem (
    .clk_i(REF_CLK_I),
    .wr_en_i(NVM_WR_I),
    .wr_addr_i(NVM_WADDR_I),
    .wr_data_i(NVM_WDATA_I),
    .rd_addr_i({set_reg, idx_reg}),
    .rd_data_o(rd_data)
  );
  always @* begin
    state_next = state_reg;
    set_next = set_reg;
    idx_next = idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_hit && len_ok && !OUT_EN_I) begin
          // upper nibble is reserved and dropped
          set_next = CMD_DATA_I[`NCR_SEL_MSB:`NCR_SEL_LSB];
          idx_next = {IDX_W{1'b0}};
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        idx_next = idx_reg + 1'b1;
        state_next = ST_COPY;
      end
      ST_COPY: begin
        if (wr_idx_reg == LAST_IDX) begin
          state_next = ST_IDLE;
        end else begin
          idx_next = idx_reg + 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  always @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_IDLE;
      set_reg <= {SEL_W{1'b0}};
      idx_reg <= {IDX_W{1'b0}};
      wr_idx_reg <= {IDX_W{1'b0}};
      copy_en_reg <= 1'b0;
      ACT_WR_O <= 1'b0;
      ACT_ADDR_O <= {IDX_W{1'b0}};
      ACT_DATA_O <= {DW{1'b0}};
      DONE_O <= 1'b0;
      REFUSED_O <= 1'b0;
      LAST_SET_O <= {SEL_W{1'b0}};
    end else begin
      state_reg <= state_next;
      set_reg <= set_next;
      idx_reg <= idx_next;
      // read data lag the address by one cycle
      copy_en_reg <= (state_reg == ST_READ) || (state_reg == ST_COPY && state_next == ST_COPY);
      if (copy_en_reg) begin
        wr_idx_reg <= wr_idx_reg + 1'b1;
      end else begin
        wr_idx_reg <= {IDX_W{1'b0}};
      end
      ACT_WR_O <= copy_en_reg;
      ACT_ADDR_O <= wr_idx_reg;
      ACT_DATA_O <= rd_data;
      DONE_O <= (state_reg == ST_COPY) && (state_next == ST_IDLE);
      if (state_reg == ST_COPY && state_next == ST_IDLE) begin
        LAST_SET_O <= set_reg;
      end
      REFUSED_O <= cmd_hit && (BUSY_O || !len_ok || OUT_EN_I);
    end
  end
endmodule // ncr_restore

// ### ncr_map.vh
// constants for the stored configuration restore block
// assumes inclusion by bare name from the design files
`ifndef NCR_MAP_VH
`define NCR_MAP_VH
`define NCR_CMD_RESTORE 8'hF2
`define NCR_SEL_LSB 0
`define NCR_SEL_MSB 3
`define NCR_RSV_LSB 4
`define NCR_RSV_MSB 7
`define NCR_NUM_SETS 16
`define NCR_WORDS_PER_SET 16
`endif

// ### ncr_mem.v
// stored configuration memory: one read port, registered read data
// assumes contents are loaded through the write port by the surrounding chip
`timescale 1ns/1ps
module ncr_mem #(
  parameter AW = 8,
  parameter DW = 16
) (
  input wire clk_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // ncr_mem

// ### ncr_host.sv
// host model for ncr_restore
// assumes posedge timing
`timescale 1ns/1ps
module ncr_host(input wire clk_i,output reg wr_o=0,output reg [7:0] c_o=0,d_o=0,l_o=0);
task send(input [7:0] c,d,l);@(posedge clk_i){wr_o,c_o,d_o,l_o}<={1'b1,c,d,l};
@(posedge clk_i){wr_o,d_o}<={1'b0,~d};endtask
endmodule // ncr_host

// ### ncr_chk.sv
// checker for ncr_restore
// assumes bind by port name
`timescale 1ns/1ps
module ncr_chk(input wire REF_CLK_I,SYS_RST_I,CMD_WR_I,OUT_EN_I,BUSY_O,ACT_WR_O,DONE_O,
input wire REFUSED_O,input wire [7:0] CMD_CODE_I,CMD_LEN_I);
default clocking @(posedge REF_CLK_I);endclocking
default disable iff(SYS_RST_I);
wire c=CMD_WR_I&&CMD_CODE_I==8'hF2;
wire t=c&&CMD_LEN_I==8'h01&&!OUT_EN_I&&!BUSY_O;
a_copy_start:assert property(t|=>BUSY_O##2 ACT_WR_O[*8])else $error("copy");
a_done_bound:assert property(t|->##[17:20] DONE_O)else $error("done");
a_en_refused:assert property(c&&OUT_EN_I&&!BUSY_O|=>REFUSED_O&&!BUSY_O)else $error("en");
a_len_refused:assert property(c&&CMD_LEN_I!=8'h01&&!BUSY_O|=>REFUSED_O&&!BUSY_O)else $error("len");
a_done_pulse:assert property(DONE_O|=>!DONE_O&&!ACT_WR_O)else $error("done pulse");
endmodule // ncr_chk
bind ncr_restore ncr_chk chk_u(.*);

// ### testbench.sv
// bench for ncr_restore
// assumes ncr_host drives commands
`timescale 1ns/1ps
module testbench;
reg k=0,r=1,e=0,n=0;reg [1:0] p=0;reg [7:0] a=0;reg [15:0] v=0;
wire w,b,q,o,f;wire [7:0] c,d,l;wire [3:0] x,s;wire [15:0] y;
int fail_count=0,samples_checked=0,i,j;
reg [7:0] rows[4]='{8'h03,8'hFC,8'hA0,8'hF5};
always #4 k=~k;
ncr_host host_u(.clk_i(k),.wr_o(w),.c_o(c),.d_o(d),.l_o(l));
ncr_restore dut_u(.REF_CLK_I(k),.SYS_RST_I(r),.CMD_WR_I(w),.CMD_CODE_I(c),.CMD_DATA_I(d),
.CMD_LEN_I(l),.PAGE_I(p),.OUT_EN_I(e),.NVM_WR_I(n),.NVM_WADDR_I(a),.NVM_WDATA_I(v),.BUSY_O(b),
.ACT_WR_O(q),.ACT_ADDR_O(x),.ACT_DATA_O(y),.DONE_O(o),.REFUSED_O(f),.LAST_SET_O(s));
task chk(input [23:0] g,h);samples_checked++;if(g!==h)begin fail_count++;
$display("BAD %0t %h %h",$time,g,h);end endtask
task print_verdict;$display("%0d %0d",samples_checked,fail_count);
if(fail_count==0&&samples_checked>0)$display("bench passed");else $display("bench failed");
$finish;endtask
task run(input [3:0] m);for(j=0;j<40&&q!==1;j++)@(posedge k)#1;
if(j>39)begin fail_count++;print_verdict;end
for(j=0;j<16;j++)begin chk({q,x,y},{1'b1,j[3:0],m,j[3:0],8'h5A});chk(o,j==15);@(posedge k)#1;end
repeat(2)@(posedge k)#1;chk({b,s},m);$display("run %h",m);endtask
initial begin repeat(5)@(posedge k);r<=0;
for(i=0;i<257;i++)@(posedge k){n,a,v}<={i<256,i[7:0],i[7:0],8'h5A};
#1;chk({b,q,o,f,s},0);$display("reset idle");
for(i=0;i<4;i++)begin @(posedge k)p<=i[1:0];host_u.send(8'hF2,rows[i],8'h01);run(rows[i][3:0]);end
for(i=0;i<3;i++)begin @(posedge k)e<=i<1; // outputs enabled only on the first pass
host_u.send(8'hF2,8'h01,{6'h0,i==1,i!=2});
#1;chk({f,b},2);$display("refuse %0d",i);end
// second request while copying is refused and the first copy runs on
@(posedge k)e<=0;host_u.send(8'hF2,8'h07,8'h01);host_u.send(8'hF2,8'h02,8'h01);
#1;chk({f,b},3);run(4'h7);
// reset in mid copy, then a restore right after release
host_u.send(8'hF2,8'h09,8'h01);repeat(5)@(posedge k);r<=1;@(posedge k)r<=0;
#1;chk({b,q,o,f,s},0);$display("reset mid copy");
host_u.send(8'hF2,8'h0C,8'h01);run(4'hC);
print_verdict;end
endmodule // testbench
